// ---- cfe_fall_inputs.sv ----
// Purpose: Falling-event source qualification, five sources
// Assumes: Register port strobes are one cycle, never together
// Notes:   Read data valid only in the cycle after the read strobe
`timescale 1ns/100ps
`include "cfe_defs.svh"
// Function
// - An enabled source in edge mode starts a delayed falling event on a high-to-low edge.
// - An enabled source in level mode gives an immediate falling event while low.
// - A disabled source never affects falling events, whatever its mode.
// - Mode bit 4 selects edge or level for the comparator 4 source.
// - Mode bits 3, 2 and 1 select edge or level for comparators 3, 2 and 1.
// - Mode bit 0 serves the pin chosen by the input pin select, with the same rules.
module cfe_fall_inputs #(
   parameter int NSRC = `CFE_NUM_SRC
) (
   // Clock and reset
   input  wire logic                 sys_clk_in,
   input  wire logic                 rst_n_in,
   // Register port
   input  wire cfe_pkg::cfe_bus_req_t bus_in,
   output logic [7:0]                rdata_out,
   // Sources: comparators 1..4 and selected pin
   input  wire logic [4:1]           cmp_in,
   input  wire logic                 sel_pin_in,
   // Falling events
   output logic                      fall_delayed_out,
   output logic                      fall_immediate_out,
   output logic [NSRC-1:0]           fall_src_delayed_out
);
   logic [7:0]      falling_event_mode_select_low_r;
   logic [7:0]      fall_src_enable_r;
   logic [NSRC-1:0] src_vec;
   logic [NSRC-1:0] dly_vec;
   logic [NSRC-1:0] imm_vec;
   logic [NSRC-1:0] lvl_vec;
   logic [7:0]      rdata_nxt;

   // Map sources onto mode and enable bit positions
   always_comb begin
      src_vec                 = '0;
      src_vec[`CFE_BIT_PIN]   = sel_pin_in;
      src_vec[`CFE_BIT_CMP1]  = cmp_in[1];
      src_vec[`CFE_BIT_CMP2]  = cmp_in[2];
      src_vec[`CFE_BIT_CMP3]  = cmp_in[3];
      src_vec[`CFE_BIT_CMP4]  = cmp_in[4];
   end

   // Mode register write
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         falling_event_mode_select_low_r <= `CFE_MODE_RESET;
      end else if (bus_in.wr && bus_in.addr == `CFE_OFF_MODE_LOW) begin
         falling_event_mode_select_low_r <= bus_in.wdata;
      end
   end

   // Enable register write
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fall_src_enable_r <= `CFE_ENABLE_RESET;
      end else if (bus_in.wr && bus_in.addr == `CFE_OFF_ENABLE_LOW) begin
         fall_src_enable_r <= bus_in.wdata;
      end
   end

   // One qualifier per source
   genvar gi;
   generate
      for (gi = 0; gi < NSRC; gi++) begin : g_src
         cfe_src_qual cfe_src_qual_i (
            .sys_clk_in    (sys_clk_in),
            .rst_n_in      (rst_n_in),
            .src_in        (src_vec[gi]),
            .enable_in     (fall_src_enable_r[gi]),
            .edge_mode_in  (falling_event_mode_select_low_r[gi]),
            .delayed_out   (dly_vec[gi]),
            .immediate_out (imm_vec[gi]),
            .sync_out      (lvl_vec[gi])
         );
      end
   endgenerate

   // Any enabled edge-mode source fell
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fall_delayed_out <= 1'b0;
      end else begin
         fall_delayed_out <= |dly_vec;
      end
   end

   // Any enabled level-mode source low
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fall_immediate_out <= 1'b0;
      end else begin
         fall_immediate_out <= |imm_vec;
      end
   end

   // Per-source edge pulses for the phase-delay stage
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fall_src_delayed_out <= '0;
      end else begin
         fall_src_delayed_out <= dly_vec;
      end
   end

   // Read decode
   always_comb begin
      rdata_nxt = 8'h00;
      if (bus_in.addr == `CFE_OFF_MODE_LOW) begin
         rdata_nxt = falling_event_mode_select_low_r;
      end else if (bus_in.addr == `CFE_OFF_ENABLE_LOW) begin
         rdata_nxt = fall_src_enable_r;
      end else if (bus_in.addr == `CFE_OFF_STATUS) begin
         rdata_nxt[NSRC-1:0] = lvl_vec; // Upper bits stay zero
      end
   end

   // Read data, one cycle after strobe only
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_out <= 8'h00;
      end else if (bus_in.rd) begin
         rdata_out <= rdata_nxt;
      end else begin
         rdata_out <= 8'h00;
      end
   end

   // Disabled pin source never yields an event
   a_disabled_quiet: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      !fall_src_enable_r[0] && !$past(fall_src_enable_r[0]) |-> !dly_vec[0] && !imm_vec[0])
      else $error("disabled source produced an event");

   // Comparator 1 in level mode, low, gives immediate event within four cycles
   a_level_event: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      (fall_src_enable_r[1] && !falling_event_mode_select_low_r[1] && !cmp_in[1])[*4]
      |-> imm_vec[1])
      else $error("level mode missed immediate event");

   // Comparator 4 edge pulse lasts exactly one cycle
   a_edge_single: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      dly_vec[4] |=> !dly_vec[4])
      else $error("edge event longer than one cycle");

   // Pin in edge mode never gives immediate events
   a_edge_no_imm: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      falling_event_mode_select_low_r[0] && $past(falling_event_mode_select_low_r[0])
      |-> !imm_vec[0])
      else $error("edge mode gave immediate event");

   // Pin source in edge mode falls, a delayed event follows
   a_edge_event: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      $past(fall_src_enable_r[0] && falling_event_mode_select_low_r[0]) && $fell(lvl_vec[0])
      |-> dly_vec[0])
      else $error("pin source edge missed");

   // Comparator 2 in edge mode falls, a delayed event follows
   a_edge_cmp2: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      $past(fall_src_enable_r[2] && falling_event_mode_select_low_r[2]) && $fell(lvl_vec[2])
      |-> dly_vec[2])
      else $error("comparator 2 edge missed");

   // Comparator 4 in edge mode falls, a delayed event follows
   a_edge_cmp4: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      $past(fall_src_enable_r[4] && falling_event_mode_select_low_r[4]) && $fell(lvl_vec[4])
      |-> dly_vec[4])
      else $error("comparator 4 edge missed");

   // Comparator 4 in level mode: immediate event tracks the low level
   a_level_follow: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      $past(fall_src_enable_r[4] && !falling_event_mode_select_low_r[4])
      |-> imm_vec[4] == !lvl_vec[4])
      else $error("comparator 4 level event wrong");

   // Comparator 3 in level mode: immediate event tracks the low level
   a_level_cmp3: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      $past(fall_src_enable_r[3] && !falling_event_mode_select_low_r[3])
      |-> imm_vec[3] == !lvl_vec[3])
      else $error("comparator 3 level event wrong");

   // Pin in level mode: immediate event tracks the low level
   a_level_pin: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      $past(fall_src_enable_r[0] && !falling_event_mode_select_low_r[0])
      |-> imm_vec[0] == !lvl_vec[0])
      else $error("pin level event wrong");

   // Disabled comparator 1 stays silent
   a_disabled_cmp1: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      !$past(fall_src_enable_r[1]) |-> !dly_vec[1] && !imm_vec[1])
      else $error("disabled comparator 1 produced an event");

   // Disabled comparator 4 stays silent
   a_disabled_cmp4: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      !$past(fall_src_enable_r[4]) |-> !dly_vec[4] && !imm_vec[4])
      else $error("disabled comparator 4 produced an event");

   // Comparator 4 in edge mode never gives an immediate event
   a_cmp4_no_imm: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      $past(falling_event_mode_select_low_r[4]) |-> !imm_vec[4])
      else $error("comparator 4 edge mode gave immediate event");

   // Pin in level mode never gives a delayed event
   a_level_no_dly: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      !$past(falling_event_mode_select_low_r[0]) |-> !dly_vec[0])
      else $error("pin level mode gave delayed event");

   // Comparator 1 edge pulse at the output lasts one cycle
   a_src1_pulse_once: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      fall_src_delayed_out[1] |=> !fall_src_delayed_out[1])
      else $error("comparator 1 edge pulse too long");

   // Mode register reads back what it holds
   a_read_mode: assert property (@(posedge sys_clk_in)
      disable iff (!rst_n_in)
      $past(bus_in.rd && bus_in.addr == `CFE_OFF_MODE_LOW)
      |-> rdata_out == $past(falling_event_mode_select_low_r))
      else $error("mode register read back wrong");
endmodule

// ---- cfe_defs.svh ----
// Purpose: Constants for the falling-event input qualifier
// Assumes: Included by bare name
// Notes:   Offsets are register addresses on the plain port
`ifndef CFE_DEFS_SVH
`define CFE_DEFS_SVH
`define CFE_ADDR_W          4
`define CFE_OFF_MODE_LOW    4'h0
`define CFE_OFF_ENABLE_LOW  4'h1
`define CFE_OFF_STATUS      4'h2
`define CFE_MODE_RESET      8'h00
`define CFE_ENABLE_RESET    8'h00
`define CFE_NUM_SRC         5
`define CFE_BIT_PIN         0
`define CFE_BIT_CMP1        1
`define CFE_BIT_CMP2        2
`define CFE_BIT_CMP3        3
`define CFE_BIT_CMP4        4
`define CFE_SYNC_STAGES     2
`endif

// ---- cfe_pkg.sv ----
// Purpose: Types for the falling-event input qualifier
// Assumes: Nothing
// Notes:   Holds types only
package cfe_pkg;
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } cfe_bus_req_t;
   typedef enum logic {CFE_LEVEL, CFE_EDGE} cfe_mode_t;
endpackage

// ---- cfe_src_qual.sv ----
// Purpose: One falling-event source: sync, edge detect, qualify
// Assumes: Source is asynchronous to sys_clk_in
// Notes:   Outputs are registered
`timescale 1ns/100ps
`include "cfe_defs.svh"
module cfe_src_qual #(
   parameter int STAGES = `CFE_SYNC_STAGES
) (
   // Clock and reset
   input  wire logic sys_clk_in,
   input  wire logic rst_n_in,
   // Source and controls
   input  wire logic src_in,
   input  wire logic enable_in,
   input  wire logic edge_mode_in,
   // Qualified events and synced source level
   output logic      delayed_out,
   output logic      immediate_out,
   output logic      sync_out
);
   logic [STAGES-1:0] sync_r;
   logic              prev_r;

   // Synchroniser chain, first stage read only by second
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync_r <= '1;
      end else begin
         sync_r <= {sync_r[STAGES-2:0], src_in};
      end
   end

   // Previous synced level for edge detect
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prev_r <= 1'b1;
      end else begin
         prev_r <= sync_r[STAGES-1];
      end
   end

   // Qualify by enable and mode
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         delayed_out   <= 1'b0;
         immediate_out <= 1'b0;
         sync_out      <= 1'b1;
      end else begin
         sync_out      <= sync_r[STAGES-1];
         // Edge: one pulse per high-to-low
         delayed_out   <= enable_in && edge_mode_in
                          && prev_r && !sync_r[STAGES-1];
         // Level: held while low
         immediate_out <= enable_in && !edge_mode_in
                          && !sync_r[STAGES-1];
      end
   end
endmodule

// ---- cfe_src_model.sv ----
// Purpose: Far side model: comparators 1..4 and selected pin
// Assumes: Bench sets levels just after a rising edge
// Notes:   Plain levels, no clock of their own
`timescale 1ns/100ps
module cfe_src_model (
   // Requested levels, bit 0 is the pin
   input  wire logic [4:0] lvl_in,
   // Source outputs
   output logic [4:1]      cmp_out,
   output logic            pin_out
);
   // Comparator outputs and selected pin level
   assign cmp_out = lvl_in[4:1];
   assign pin_out = lvl_in[0];
endmodule

// ---- cfe_fall_inputs_bench.sv ----
// Purpose: Self-checking bench for the falling-event qualifier
// Assumes: Register port answers one cycle after the read strobe
// Notes:   Rows give source, mode, enable and expected outputs
`timescale 1ns/100ps
`include "cfe_defs.svh"
module cfe_fall_inputs_bench;
   logic                 sys_clk;
   logic                 rst_n;
   cfe_pkg::cfe_bus_req_t bus;
   logic [7:0]           rdata;
   logic [4:0]           lvl;
   logic [4:1]           cmp;
   logic                 pin;
   logic                 f_dly;
   logic                 f_imm;
   logic [4:0]           s_dly;
   logic [7:0]           m;
   logic [6:0]           r;
   int                   err_total;
   int                   total_checks;
   // Rows: {source[2:0], mode, enable, expected delayed, expected immediate}
   logic [6:0]           rows [12] = '{7'h0e, 7'h05, 7'h1e, 7'h15, 7'h2e, 7'h25,
                                       7'h3e, 7'h35, 7'h4e, 7'h45, 7'h20, 7'h48};
   // Design and source model
   cfe_fall_inputs cfe_fall_inputs_i (.sys_clk_in(sys_clk), .rst_n_in(rst_n),
      .bus_in(bus), .rdata_out(rdata), .cmp_in(cmp), .sel_pin_in(pin),
      .fall_delayed_out(f_dly), .fall_immediate_out(f_imm), .fall_src_delayed_out(s_dly));
   cfe_src_model cfe_src_model_i (.lvl_in(lvl), .cmp_out(cmp), .pin_out(pin));
   // 50 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   // Compare and count
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   // One-cycle register write
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus.wr <= 1'b1;
      bus.addr <= a;
      bus.wdata <= d;
      @(posedge sys_clk);
      bus.wr <= 1'b0;
   endtask
   // One-cycle register read, data checked in the following cycle
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      bus.rd <= 1'b1;
      bus.addr <= a;
      @(posedge sys_clk);
      bus.rd <= 1'b0;
      #1;
      chk(rdata, e);
   endtask
   // Counts and verdict
   task automatic results();
      $display("Checks %0d, mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Run limit
   initial begin
      #1ms;
      err_total++;
      results();
   end
   // Main sequence
   initial begin
      err_total = 0;
      total_checks = 0;
      bus = '0;
      lvl = 5'h1f;
      rst_n = 1'b0;
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      // Reset values, unmapped address, synced levels
      rd(`CFE_OFF_MODE_LOW, `CFE_MODE_RESET);
      rd(`CFE_OFF_ENABLE_LOW, `CFE_ENABLE_RESET);
      rd(4'hf, 8'h00);
      rd(`CFE_OFF_STATUS, 8'h1f);
      chk({f_dly, f_imm, s_dly}, 8'h00);
      $display("Reset test done");
      // One row: configure, drop the source, watch outputs
      foreach (rows[n]) begin
         r = rows[n];
         m = 8'h01 << r[6:4];
         wr(`CFE_OFF_MODE_LOW, r[3] ? m : 8'h00);
         wr(`CFE_OFF_ENABLE_LOW, r[2] ? m : 8'h00);
         rd(`CFE_OFF_MODE_LOW, r[3] ? m : 8'h00);
         @(posedge sys_clk);
         lvl <= ~m[4:0];
         repeat (4) @(posedge sys_clk);
         #1;
         chk(f_dly, r[1]);
         chk(s_dly, r[1] ? m[4:0] : 5'h00);
         chk(f_imm, r[0]);
         @(posedge sys_clk);
         #1;
         chk(f_dly, 1'b0);
         chk(f_imm, r[0]);
         rd(`CFE_OFF_STATUS, {3'h0, ~m[4:0]});
         @(posedge sys_clk);
         lvl <= 5'h1f;
         repeat (6) @(posedge sys_clk);
         #1;
         chk(f_imm, 1'b0);
         $display("Row %0d done", n);
      end
      // Two edge sources and one level source fall together
      wr(`CFE_OFF_MODE_LOW, 8'h03);
      wr(`CFE_OFF_ENABLE_LOW, 8'h07);
      @(posedge sys_clk);
      lvl <= 5'h18;
      repeat (4) @(posedge sys_clk);
      #1;
      chk(f_dly, 1'b1);
      chk(s_dly, 8'h03);
      chk(f_imm, 1'b1);
      // Rising edges in edge mode give nothing
      @(posedge sys_clk);
      lvl <= 5'h1f;
      repeat (6) begin
         @(posedge sys_clk);
         #1;
         chk(f_dly, 1'b0);
      end
      chk(f_imm, 1'b0);
      $display("Multi-source test done");
      // Reset in mid-run with a level source held low
      @(posedge sys_clk);
      lvl <= 5'h1b;
      repeat (4) @(posedge sys_clk);
      #1;
      chk(f_imm, 1'b1);
      @(posedge sys_clk);
      rst_n <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk({f_dly, f_imm, s_dly}, 8'h00);
      chk(rdata, 8'h00);
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      rd(`CFE_OFF_MODE_LOW, `CFE_MODE_RESET);
      rd(`CFE_OFF_ENABLE_LOW, `CFE_ENABLE_RESET);
      repeat (4) @(posedge sys_clk);
      #1;
      chk(f_imm, 1'b0);
      rd(`CFE_OFF_STATUS, 8'h1b);
      @(posedge sys_clk);
      lvl <= 5'h1f;
      $display("Mid-run reset test done");
      results();
   end
endmodule
